// [core/dsgate_cfg.svh]
// offsets, field positions, reset values and masks of the clock gating bank
`ifndef DSGATE_CFG_SVH
`define DSGATE_CFG_SVH

// byte offsets within the system control window
`define DSG_ADDR_W 12
`define DSG_OFF_RUN_CFG 12'h060
`define DSG_OFF_RUN_GATE 12'h104
`define DSG_OFF_SLEEP_GATE 12'h114
`define DSG_OFF_DEEP_GATE 12'h124
`define DSG_OFF_IRQ_STATUS 12'h200
`define DSG_OFF_IRQ_MASK 12'h204
`define DSG_OFF_FAULT_UNIT 12'h208

// gate bit positions, one per controlled unit
`define DSG_BIT_ASYNC0 0
`define DSG_BIT_ASYNC1 1
`define DSG_BIT_ASYNC2 2
`define DSG_BIT_SYNC_SERIAL 4
`define DSG_BIT_QUAD_DEC 8
`define DSG_BIT_TWO_WIRE 12
`define DSG_BIT_COUNTER0 16
`define DSG_BIT_COUNTER1 17
`define DSG_BIT_COUNTER2 18
`define DSG_BIT_COMPARATOR_ZERO_GATE 24
`define DSG_BIT_COMPARATOR_1_GATE 25
`define DSG_BIT_COMPARATOR_2_GATE 26

// writable bits of each gating word, everything else reads zero
`define DSG_GATE_WMASK 32'h0707_1117
`define DSG_GATE_RESET 32'h0000_0000

// run clock configuration: auto gating select bit
`define DSG_BIT_AUTO_GATING 27
`define DSG_CFG_WMASK 32'h0800_0000
`define DSG_CFG_RESET 32'h0000_0000

// interrupt status and mask layout
`define DSG_IRQ_W 2
`define DSG_IRQ_BIT_FAULT 0
`define DSG_IRQ_BIT_DEEP_ENTRY 1
`define DSG_IRQ_RESET 2'h0

`endif

// [core/dsgate_pkg.sv]
// types shared by the deep sleep clock gating bank
package dsgate_pkg;

    // power state the system reports to the gating bank
    typedef enum logic [1:0] {
        PM_RUN = 2'b00,
        PM_SLEEP = 2'b01,
        PM_DEEP = 2'b10
    } power_mode_t;

    // avalon-mm request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [11:0] address;
        logic [31:0] writedata;
    } bus_req_t;

    // avalon-mm answer from the slave
    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } bus_rsp_t;

    // one peripheral access to be checked against the gates
    typedef struct packed {
        logic valid;
        logic [4:0] unit;
    } periph_req_t;

    // verdict on a peripheral access, one cycle later
    typedef struct packed {
        logic ok;
        logic fault;
        logic [4:0] unit;
    } periph_rsp_t;

endpackage

// [core/gate_select.sv]
// picks the applied enable word from the run, sleep and deep sleep copies
`timescale 1ns/1ps
module gate_select #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // gating copies and selection
    input wire logic [WIDTH-1:0] run_gate,
    input wire logic [WIDTH-1:0] sleep_gate,
    input wire logic [WIDTH-1:0] deep_gate,
    input wire logic auto_gating_select,
    input wire dsgate_pkg::power_mode_t mode,
    // applied clock enables
    output logic [WIDTH-1:0] clk_en
);

    typedef struct packed {
        logic [WIDTH-1:0] en;
    } sel_state_t;

    sel_state_t state;
    sel_state_t next_state;
    logic [WIDTH-1:0] pick;

    // per bit choice; run copy unless auto gating picks a low power copy
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            assign pick[i] = !auto_gating_select ? run_gate[i] :
                (mode == dsgate_pkg::PM_DEEP) ? deep_gate[i] :
                (mode == dsgate_pkg::PM_SLEEP) ? sleep_gate[i] : run_gate[i];
        end
    endgenerate

    // registered so the enables never glitch
    always_comb begin
        next_state = state;
        next_state.en = pick;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign clk_en = state.en;

    deep_select_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        auto_gating_select && mode == dsgate_pkg::PM_DEEP |=> clk_en == $past(deep_gate))
        else $error("deep sleep copy not applied");

    run_select_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !auto_gating_select |=> clk_en == $past(run_gate))
        else $error("run copy not applied without auto gating");

endmodule

// [core/access_fault_check.sv]
// answers peripheral accesses, faulting those aimed at an unclocked unit
`timescale 1ns/1ps
module access_fault_check #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // applied enables and the access to check
    input wire logic [WIDTH-1:0] clk_en,
    input wire dsgate_pkg::periph_req_t access,
    // verdict
    output dsgate_pkg::periph_rsp_t verdict
);

    typedef struct packed {
        logic ok;
        logic fault;
        logic [4:0] unit;
    } chk_state_t;

    chk_state_t state;
    chk_state_t next_state;

    // reserved positions have no enable and so always fault
    always_comb begin
        next_state = state;
        next_state.ok = access.valid && clk_en[access.unit];
        next_state.fault = access.valid && !clk_en[access.unit];
        if (access.valid) begin
            next_state.unit = access.unit;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign verdict.ok = state.ok;
    assign verdict.fault = state.fault;
    assign verdict.unit = state.unit;

    gated_fault_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        access.valid && !clk_en[access.unit] |=> verdict.fault && !verdict.ok)
        else $error("access to unclocked unit not faulted");

    clocked_ok_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        access.valid && clk_en[access.unit] |=> verdict.ok && !verdict.fault)
        else $error("access to clocked unit faulted");

endmodule

// [core/deep_sleep_clock_gate_bank.sv]
// clock gating bank with run, sleep and deep sleep copies and fault checking
//
// Notes on behaviour
// - one enable bit per controlled unit, each bit gating exactly one unit.
// - bit set clocks the unit; bit clear leaves it unclocked and disabled.
// - any access to an unclocked unit is answered with a bus fault.
// - all implemented enable bits reset to zero.
// - three copies with one layout: run, sleep and deep sleep.
// - sleep and deep sleep copies apply only while auto gating is selected.
// - deep sleep copy sits at offset 0x124, read/write, resets to zero.
// - bits that gate no unit are read-only.
`timescale 1ns/1ps
`include "dsgate_cfg.svh"
module deep_sleep_clock_gate_bank #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // avalon-mm register slave
    input wire dsgate_pkg::bus_req_t bus_req,
    output dsgate_pkg::bus_rsp_t bus_rsp,
    // power state of the system
    input wire dsgate_pkg::power_mode_t power_mode,
    // peripheral access check
    input wire dsgate_pkg::periph_req_t periph_req,
    output dsgate_pkg::periph_rsp_t periph_rsp,
    // per unit clock enables
    output logic [WIDTH-1:0] unit_clk_en,
    // interrupt
    output logic irq
);

    // whole register and handshake state
    typedef struct packed {
        logic [WIDTH-1:0] run_gate;
        logic [WIDTH-1:0] sleep_gate;
        logic [WIDTH-1:0] deep_gate;
        logic [WIDTH-1:0] run_cfg;
        logic [`DSG_IRQ_W-1:0] irq_status;
        logic [`DSG_IRQ_W-1:0] irq_mask;
        logic [4:0] fault_unit;
        logic ack;
        logic [WIDTH-1:0] readdata;
        dsgate_pkg::power_mode_t mode;
    } bank_state_t;

    bank_state_t state;
    bank_state_t next_state;

    logic req;
    logic commit;
    logic auto_gating;
    logic deep_entry;
    logic [WIDTH-1:0] gate_wmask;
    logic [WIDTH-1:0] cfg_wmask;
    logic [WIDTH-1:0] read_word;
    logic [`DSG_IRQ_W-1:0] irq_events;
    logic [`DSG_IRQ_W-1:0] irq_clear;
    logic [WIDTH-1:0] applied_en;
    dsgate_pkg::periph_rsp_t verdict;

    // write masks keep reserved positions at zero
    assign gate_wmask = WIDTH'(`DSG_GATE_WMASK);
    assign cfg_wmask = WIDTH'(`DSG_CFG_WMASK);

    // bus handshake: one wait cycle, then the access completes
    assign req = bus_req.read || bus_req.write;
    assign commit = req && state.ack;

    // auto gating select lives in the run clock configuration word
    assign auto_gating = state.run_cfg[`DSG_BIT_AUTO_GATING];

    // deep sleep entry under auto gating: live mode is deep while the registered mode is not
    assign deep_entry = auto_gating && (power_mode == dsgate_pkg::PM_DEEP)
        && (state.mode != dsgate_pkg::PM_DEEP);

    // sticky event sources
    always_comb begin
        irq_events = '0;
        irq_events[`DSG_IRQ_BIT_FAULT] = verdict.fault;
        irq_events[`DSG_IRQ_BIT_DEEP_ENTRY] = deep_entry;
    end

    // write one to clear, taken only at the completing edge
    always_comb begin
        irq_clear = '0;
        if (commit && bus_req.write && bus_req.address == `DSG_OFF_IRQ_STATUS) begin
            irq_clear = bus_req.writedata[`DSG_IRQ_W-1:0];
        end
    end

    // read decode; unmapped addresses read zero
    always_comb begin
        read_word = '0;
        unique case (bus_req.address)
            `DSG_OFF_RUN_CFG: begin
                read_word = state.run_cfg;
            end
            `DSG_OFF_RUN_GATE: begin
                read_word = state.run_gate;
            end
            `DSG_OFF_SLEEP_GATE: begin
                read_word = state.sleep_gate;
            end
            `DSG_OFF_DEEP_GATE: begin
                read_word = state.deep_gate;
            end
            `DSG_OFF_IRQ_STATUS: begin
                read_word = WIDTH'(state.irq_status);
            end
            `DSG_OFF_IRQ_MASK: begin
                read_word = WIDTH'(state.irq_mask);
            end
            `DSG_OFF_FAULT_UNIT: begin
                read_word = WIDTH'(state.fault_unit);
            end
            default: begin
                read_word = '0;
            end
        endcase
    end

    // next state of the whole bank
    always_comb begin
        next_state = state;
        next_state.mode = power_mode;
        // ack toggles so a held request completes every second cycle
        next_state.ack = req && !state.ack;
        // read data captured in the wait cycle, stands at the completing edge
        if (req && !state.ack) begin
            next_state.readdata = read_word;
        end
        // register writes land only at the completing edge
        if (commit && bus_req.write) begin
            unique case (bus_req.address)
                `DSG_OFF_RUN_CFG: begin
                    next_state.run_cfg = bus_req.writedata & cfg_wmask;
                end
                `DSG_OFF_RUN_GATE: begin
                    next_state.run_gate = bus_req.writedata & gate_wmask;
                end
                `DSG_OFF_SLEEP_GATE: begin
                    next_state.sleep_gate = bus_req.writedata & gate_wmask;
                end
                `DSG_OFF_DEEP_GATE: begin
                    next_state.deep_gate = bus_req.writedata & gate_wmask;
                end
                `DSG_OFF_IRQ_MASK: begin
                    next_state.irq_mask = bus_req.writedata[`DSG_IRQ_W-1:0];
                end
                default: begin
                    next_state.run_cfg = state.run_cfg;
                end
            endcase
        end
        // a new event beats a clear in the same cycle
        next_state.irq_status = (state.irq_status & ~irq_clear) | irq_events;
        // remember which unit was hit by the latest fault
        if (verdict.fault) begin
            next_state.fault_unit = verdict.unit;
        end
    end

    // state register; all gates start off so nothing is clocked
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state.run_gate <= `DSG_GATE_RESET;
            state.sleep_gate <= `DSG_GATE_RESET;
            state.deep_gate <= `DSG_GATE_RESET;
            state.run_cfg <= `DSG_CFG_RESET;
            state.irq_status <= `DSG_IRQ_RESET;
            state.irq_mask <= `DSG_IRQ_RESET;
            state.fault_unit <= 5'h00;
            state.ack <= 1'b0;
            state.readdata <= 32'h0000_0000;
            state.mode <= dsgate_pkg::PM_RUN;
        end else begin
            state <= next_state;
        end
    end

    // applied enables follow the copy that the power state selects under auto gating, else the run copy
    gate_select #(
        .WIDTH(WIDTH)
    ) u_select (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .run_gate(state.run_gate),
        .sleep_gate(state.sleep_gate),
        .deep_gate(state.deep_gate),
        .auto_gating_select(auto_gating),
        .mode(power_mode),
        .clk_en(applied_en)
    );

    // accesses checked against the enables actually applied
    access_fault_check #(
        .WIDTH(WIDTH)
    ) u_check (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clk_en(applied_en),
        .access(periph_req),
        .verdict(verdict)
    );

    // outputs
    assign unit_clk_en = applied_en;
    assign periph_rsp = verdict;
    assign bus_rsp.readdata = state.readdata;
    assign bus_rsp.waitrequest = req && !state.ack;
    assign irq = |(state.irq_status & state.irq_mask);

    // helper: has the deep copy been written since reset
    logic deep_written;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            deep_written <= 1'b0;
        end else if (commit && bus_req.write && bus_req.address == `DSG_OFF_DEEP_GATE) begin
            deep_written <= 1'b1;
        end
    end

    // waitrequest drops exactly one cycle into a held request
    wait_one_cycle_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        req && !state.ack ##1 req |-> !bus_rsp.waitrequest)
        else $error("waitrequest not released after one cycle");

    // deep copy write lands masked at the completing edge
    deep_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        commit && bus_req.write && bus_req.address == `DSG_OFF_DEEP_GATE
        |=> state.deep_gate == ($past(bus_req.writedata) & 32'h0707_1117))
        else $error("deep copy write not stored");

    // deep copy reads back what it holds
    deep_read_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        req && !state.ack && bus_req.read && bus_req.address == `DSG_OFF_DEEP_GATE
        ##1 req |-> bus_rsp.readdata == state.deep_gate)
        else $error("deep copy read returned wrong data");

    // reserved positions never hold a one
    reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (state.deep_gate & ~32'h0707_1117) == 32'h0000_0000)
        else $error("reserved bit of deep copy set");

    // deep copy stays zero until software writes it
    reset_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !deep_written |-> state.deep_gate == 32'h0000_0000)
        else $error("deep copy not zero after reset");

    // a fault verdict raises the sticky status bit
    fault_sticky_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        verdict.fault |=> state.irq_status[0])
        else $error("fault event lost");

    // an unmasked fault verdict drives the interrupt on the next cycle
    irq_level_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        verdict.fault && state.irq_mask[0] && !(commit && bus_req.write
        && bus_req.address == `DSG_OFF_IRQ_MASK) |=> irq)
        else $error("interrupt not raised for unmasked fault");

    // in deep sleep with auto gating an unset deep bit faults its unit
    deep_fault_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        auto_gating && power_mode == dsgate_pkg::PM_DEEP
        && $stable(state.deep_gate) && $stable(power_mode) && $stable(auto_gating)
        && periph_req.valid && !state.deep_gate[periph_req.unit] |=> periph_rsp.fault)
        else $error("unclocked unit in deep sleep not faulted");

    // sleep copy applies in sleep with auto gating
    sleep_select_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        auto_gating && power_mode == dsgate_pkg::PM_SLEEP
        |=> unit_clk_en == $past(state.sleep_gate))
        else $error("sleep copy not applied");

    // run copy still applies in the run state with auto gating
    run_state_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        auto_gating && power_mode == dsgate_pkg::PM_RUN
        |=> unit_clk_en == $past(state.run_gate))
        else $error("run copy not applied in run state");

    // run copy write lands masked at the completing edge
    run_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        commit && bus_req.write && bus_req.address == `DSG_OFF_RUN_GATE
        |=> state.run_gate == ($past(bus_req.writedata) & gate_wmask))
        else $error("run copy write not stored");

    // sleep copy write lands masked at the completing edge
    sleep_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        commit && bus_req.write && bus_req.address == `DSG_OFF_SLEEP_GATE
        |=> state.sleep_gate == ($past(bus_req.writedata) & gate_wmask))
        else $error("sleep copy write not stored");

    // only the auto gating select bit of the run configuration is writable
    cfg_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        commit && bus_req.write && bus_req.address == `DSG_OFF_RUN_CFG
        |=> state.run_cfg == ($past(bus_req.writedata) & cfg_wmask))
        else $error("run configuration write not stored");

    // reserved positions of the run and sleep copies never hold a one
    reserved_copies_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (state.run_gate & ~gate_wmask) == '0 && (state.sleep_gate & ~gate_wmask) == '0)
        else $error("reserved bit of run or sleep copy set");

    // run copy reads back what it holds
    run_read_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        req && !state.ack && bus_req.read && bus_req.address == `DSG_OFF_RUN_GATE
        ##1 req |-> bus_rsp.readdata == state.run_gate)
        else $error("run copy read returned wrong data");

    // a fresh request always sees one wait cycle first
    first_wait_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        req && !$past(req) |-> bus_rsp.waitrequest)
        else $error("fresh request not held off");

    // writing one clears the fault bit when no new fault arrives
    status_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        commit && bus_req.write && bus_req.address == `DSG_OFF_IRQ_STATUS
        && bus_req.writedata[`DSG_IRQ_BIT_FAULT] && !verdict.fault
        |=> !state.irq_status[`DSG_IRQ_BIT_FAULT])
        else $error("fault status not cleared by write of one");

    // entering deep sleep under auto gating raises the entry event
    entry_event_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        auto_gating && power_mode == dsgate_pkg::PM_DEEP && state.mode != dsgate_pkg::PM_DEEP
        |=> state.irq_status[`DSG_IRQ_BIT_DEEP_ENTRY])
        else $error("deep sleep entry event lost");

    // mask write lands at the completing edge
    mask_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        commit && bus_req.write && bus_req.address == `DSG_OFF_IRQ_MASK
        |=> {30'h0, state.irq_mask} == ($past(bus_req.writedata) & 32'h0000_0003))
        else $error("interrupt mask write not stored");

    // nothing masked in means the interrupt stays low
    masked_quiet_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        state.irq_mask == 2'h0 |-> !irq)
        else $error("interrupt raised while fully masked");

    // the latest faulting unit is kept for software
    fault_unit_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        verdict.fault |=> state.fault_unit == $past(verdict.unit))
        else $error("faulting unit not recorded");

endmodule

// [test/tb.sv]
// self-checking bench for the deep sleep clock gating bank
`timescale 1ns/1ps
`include "dsgate_cfg.svh"
module tb;
    // writable enables: comparators, counters, quadrature decoder, serial units
    localparam logic [31:0] GATE_BITS = 32'h0707_1117;
    localparam logic [31:0] AUTO_BIT = 32'h0800_0000;

    // design ports
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    dsgate_pkg::bus_req_t bus_req = '0;
    dsgate_pkg::bus_rsp_t bus_rsp;
    dsgate_pkg::power_mode_t power_mode = dsgate_pkg::PM_RUN;
    dsgate_pkg::periph_req_t periph_req = '0;
    dsgate_pkg::periph_rsp_t periph_rsp;
    logic [31:0] unit_clk_en;
    logic irq;

    // bookkeeping and expected-result queues
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    int seed = 32'h1801;
    logic [31:0] rd_q[$];
    logic [6:0] vq[$];
    logic [31:0] exp_rd;
    logic [6:0] exp_v;
    logic [31:0] run_v;
    logic [31:0] sleep_v;
    logic [31:0] deep_v;

    deep_sleep_clock_gate_bank #(.WIDTH(32)) DUT (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .bus_req(bus_req),
        .bus_rsp(bus_rsp),
        .power_mode(power_mode),
        .periph_req(periph_req),
        .periph_rsp(periph_rsp),
        .unit_clk_en(unit_clk_en),
        .irq(irq)
    );

    // 25 mhz clock
    always #20 ref_clk = ~ref_clk;

    task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("counts: %0d compares, %0d mismatches", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    // avalon master: held until the edge that samples waitrequest low, released there
    task automatic bus_op(input logic is_rd, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus_req <= '{read: is_rd, write: !is_rd, address: a, writedata: d};
        @(posedge ref_clk);
        while (bus_rsp.waitrequest !== 1'b0) begin
            @(posedge ref_clk);
        end
        bus_req <= '0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus_op(1'b0, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        bus_op(1'b1, a, 32'h0);
    endtask

    // one access per call; back-to-back calls keep valid high every cycle
    task automatic access(input logic [4:0] u, input logic exp_fault);
        @(posedge ref_clk);
        periph_req <= '{valid: 1'b1, unit: u};
        vq.push_back({!exp_fault, exp_fault, u});
    endtask

    // enables are registered, so give the change an edge to land
    task automatic settle();
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic set_mode(input dsgate_pkg::power_mode_t m);
        @(posedge ref_clk);
        power_mode <= m;
        settle();
    endtask

    // watcher: results taken at the completing edge, matched against the oldest note
    always @(posedge ref_clk) begin
        if (nrst && bus_req.read && bus_rsp.waitrequest === 1'b0) begin
            exp_rd = (rd_q.size() > 0) ? rd_q.pop_front() : 32'hx;
            cmp32("readdata", exp_rd, bus_rsp.readdata);
        end
        if (nrst && (periph_rsp.ok !== 1'b0 || periph_rsp.fault !== 1'b0)) begin
            exp_v = (vq.size() > 0) ? vq.pop_front() : 7'hx;
            cmp32("verdict", {25'h0, exp_v},
                {25'h0, periph_rsp.ok, periph_rsp.fault, periph_rsp.unit});
        end
    end

    // hang guard, far above the 170 or so cycles the tests need
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            $display("run timed out");
            complete_run();
        end
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        // every register starts cleared, all units unclocked
        rd(`DSG_OFF_DEEP_GATE, 32'h0);
        rd(`DSG_OFF_RUN_GATE, 32'h0);
        rd(`DSG_OFF_SLEEP_GATE, 32'h0);
        rd(`DSG_OFF_RUN_CFG, 32'h0);
        rd(`DSG_OFF_IRQ_STATUS, 32'h0);
        rd(`DSG_OFF_IRQ_MASK, 32'h0);
        cmp32("unit_clk_en", 32'h0, unit_clk_en);
        end_test("reset values");

        // reserved bits stay zero; enable bits hold what was written
        wr(`DSG_OFF_DEEP_GATE, 32'hffff_ffff);
        rd(`DSG_OFF_DEEP_GATE, GATE_BITS);
        wr(`DSG_OFF_DEEP_GATE, ~GATE_BITS);
        rd(`DSG_OFF_DEEP_GATE, 32'h0);
        run_v = $random(seed);
        sleep_v = $random(seed);
        deep_v = $random(seed);
        wr(`DSG_OFF_RUN_GATE, run_v);
        wr(`DSG_OFF_SLEEP_GATE, sleep_v);
        wr(`DSG_OFF_DEEP_GATE, deep_v);
        run_v = run_v & GATE_BITS;
        sleep_v = sleep_v & GATE_BITS;
        deep_v = deep_v & GATE_BITS;
        rd(`DSG_OFF_RUN_GATE, run_v);
        rd(`DSG_OFF_SLEEP_GATE, sleep_v);
        rd(`DSG_OFF_DEEP_GATE, deep_v);
        wr(12'h300, 32'hffff_ffff);
        rd(12'h300, 32'h0);
        end_test("register access");

        // without auto gating the run copy applies in deep sleep and sleep; with it each state applies its own copy
        set_mode(dsgate_pkg::PM_DEEP);
        cmp32("unit_clk_en", run_v, unit_clk_en);
        set_mode(dsgate_pkg::PM_SLEEP);
        cmp32("unit_clk_en", run_v, unit_clk_en);
        wr(`DSG_OFF_RUN_CFG, 32'hffff_ffff);
        rd(`DSG_OFF_RUN_CFG, AUTO_BIT);
        settle();
        cmp32("unit_clk_en", sleep_v, unit_clk_en);
        set_mode(dsgate_pkg::PM_RUN);
        cmp32("unit_clk_en", run_v, unit_clk_en);
        set_mode(dsgate_pkg::PM_DEEP);
        cmp32("unit_clk_en", deep_v, unit_clk_en);
        end_test("copy selection");

        // every unit index, back to back; unmapped indices always fault
        for (int u = 0; u < 32; u++) begin
            access(u[4:0], !deep_v[u]);
        end
        @(posedge ref_clk);
        periph_req <= '0;
        settle();
        // fault and deep entry events are pending but masked
        rd(`DSG_OFF_IRQ_STATUS, 32'h3);
        rd(`DSG_OFF_FAULT_UNIT, 32'd31);
        cmp32("irq", 32'h0, {31'h0, irq});
        end_test("access check");

        // interrupt unmasked, cleared by writing one, per event
        wr(`DSG_OFF_IRQ_MASK, 32'h1);
        settle();
        cmp32("irq", 32'h1, {31'h0, irq});
        wr(`DSG_OFF_IRQ_STATUS, 32'h1);
        settle();
        cmp32("irq", 32'h0, {31'h0, irq});
        rd(`DSG_OFF_IRQ_STATUS, 32'h2);
        wr(`DSG_OFF_IRQ_MASK, 32'h3);
        settle();
        cmp32("irq", 32'h1, {31'h0, irq});
        wr(`DSG_OFF_IRQ_STATUS, 32'h2);
        settle();
        cmp32("irq", 32'h0, {31'h0, irq});
        rd(`DSG_OFF_IRQ_STATUS, 32'h0);
        // a fault while unmasked raises the line two cycles after the access
        access(5'd3, 1'b1);
        @(posedge ref_clk);
        periph_req <= '0;
        settle();
        cmp32("irq", 32'h1, {31'h0, irq});
        rd(`DSG_OFF_IRQ_STATUS, 32'h1);
        rd(`DSG_OFF_FAULT_UNIT, 32'd3);
        end_test("interrupt");

        // second reset in mid-run drops every enable again
        @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        settle();
        cmp32("unit_clk_en", 32'h0, unit_clk_en);
        rd(`DSG_OFF_DEEP_GATE, 32'h0);
        access(5'd0, 1'b1);
        @(posedge ref_clk);
        periph_req <= '0;
        settle();
        cmp32("pending", 32'h0, rd_q.size() + vq.size());
        end_test("second reset");
        complete_run();
    end
endmodule
